// >>> cgc_top.sv
// programmable clock generator: source select, divider, pin drive, APB registers
// Operation
// - with run-in-standby clear the generator stops in standby and the pin shows the off level.
// - with run-in-standby set the generator keeps running and driving its pin in standby.
// - with divide mode clear the output is the source divided by the division factor.
// - with divide mode set the output is the source divided by two to the power N+1, with N capped at 15.
// - the pin output enable routes the clock to the pin unless the pin is the chosen source.
// - the off level sets the pin when the generator is off or the pin output is disabled.
// - an off level of 0 holds the pin low, and 1 holds it high, while no clock is output.
// - the duty balance bit gives a 50/50 duty cycle for odd division factors.
// - the generator on bit enables the generator when set and disables it when cleared.
// - the 5-bit source select field picks the clock source that feeds the divider.
//
// Chosen here: the address map and the APB slave port.
module cgc_top
  import cgc_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [CGC_NSRC-1:0] src_clk_i,
  input wire logic standby_i,
  input wire logic generator_clock_pin_i,
  output logic generator_clock_pin_o,
  output logic generator_clock_pin_oe_o,
  output logic gen_clk_o,
  output logic gen_clk_en_o
);

  cgc_div_if dv ();

  // ----------------------------------------------------------------
  // divisor arithmetic
  // ----------------------------------------------------------------
  // number of source periods per output period
  function automatic logic [CGC_HALF_W-1:0] cgc_periods(input logic mode,
                                                       input logic [15:0] n);
    logic [15:0] e;
    e = (n > CGC_POW_MAX) ? CGC_POW_MAX : n;
    if (mode) begin
      cgc_periods = 18'h0_0001 << (e[4:0] + 5'h01);
    end else if (n <= 16'h0001) begin
      cgc_periods = 18'h0_0001;
    end else begin
      cgc_periods = {2'b00, n};
    end
  endfunction : cgc_periods

  // high time in source half periods
  function automatic logic [CGC_HALF_W-1:0] cgc_high(input logic [CGC_HALF_W-1:0] d,
                                                    input logic bal);
    if (bal || d == 18'h0_0001) begin
      cgc_high = d;
    end else begin
      cgc_high = {d[CGC_HALF_W-1:1], 1'b0};
    end
  endfunction : cgc_high

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [31:0] ctrl_q;
  logic [4:0] src_sel;
  logic gen_on;
  logic duty_bal;
  logic off_lvl;
  logic pin_oe_bit;
  logic div_mode;
  logic run_stby;
  logic [15:0] div_fact;
  logic pin_is_src;

  assign src_sel = ctrl_q[CGC_SRC_LSB +: CGC_SRC_W];
  assign gen_on = ctrl_q[CGC_GEN_ON_BIT];
  assign duty_bal = ctrl_q[CGC_DUTY_BAL_BIT];
  assign off_lvl = ctrl_q[CGC_OFF_LVL_BIT];
  assign pin_oe_bit = ctrl_q[CGC_PIN_OE_BIT];
  assign div_mode = ctrl_q[CGC_DIV_MODE_BIT];
  assign run_stby = ctrl_q[CGC_RUN_STBY_BIT];
  assign div_fact = ctrl_q[CGC_DIV_LSB +: CGC_DIV_W];
  assign pin_is_src = (src_sel == CGC_PIN_SRC_IDX);

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  // zero wait states: every access completes in its first access cycle
  logic acc;
  logic wr_ctrl;
  logic rd_setup;
  logic [31:0] rd_mux;
  logic hit_ctrl;
  logic hit_stat;
  logic [31:0] bmask;
  logic [31:0] stat_w;
  cgc_state_e state_q;

  assign acc = psel_i && penable_i;
  assign wr_ctrl = acc && pwrite_i && hit_ctrl;
  assign rd_setup = psel_i && !penable_i && !pwrite_i;
  assign hit_ctrl = (paddr_i == CGC_GEN_CTRL_OFS);
  assign hit_stat = (paddr_i == CGC_GEN_STAT_OFS);
  assign pready_o = 1'b1;
  // writes to the status word are refused with an error, never dropped silently
  assign pslverr_o = acc && !(hit_ctrl || (hit_stat && !pwrite_i));
  assign bmask = {{8{pstrb_i[3]}}, {8{pstrb_i[2]}}, {8{pstrb_i[1]}}, {8{pstrb_i[0]}}};

  always_comb begin
    stat_w = '0;
    stat_w[CGC_ST_RUN_BIT] = (state_q != CGC_OFF);
    stat_w[CGC_ST_LVL_BIT] = dv.gen_q;
    stat_w[CGC_ST_DRAIN_BIT] = (state_q == CGC_DRAIN);
    stat_w[CGC_ST_PINSRC_BIT] = pin_is_src;
  end

  // unmapped addresses read as zero
  always_comb begin
    rd_mux = '0;
    if (hit_ctrl) begin
      rd_mux = ctrl_q;
    end else if (hit_stat) begin
      rd_mux = stat_w;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      ctrl_q <= CGC_GEN_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_q <= (ctrl_q & ~(bmask & CGC_GEN_CTRL_WMASK)) |
                (pwdata_i & bmask & CGC_GEN_CTRL_WMASK);
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      prdata_o <= '0;
    end else if (rd_setup) begin
      // loaded in the setup cycle so the data stands throughout the access
      prdata_o <= rd_mux;
    end
  end

  // ----------------------------------------------------------------
  // source synchronisers
  // ----------------------------------------------------------------
  logic [CGC_NSRC-1:0] src_raw;
  logic [CGC_NSRC-1:0] sync1_q;
  logic [CGC_NSRC-1:0] sync2_q;
  logic [CGC_NSRC-1:0] sync3_q;
  logic [CGC_NSRC-1:0] lvl_q;
  logic [CGC_NSRC-1:0] agree;

  // the pin itself becomes a source in its own slot
  always_comb begin
    src_raw = src_clk_i;
    src_raw[CGC_PIN_SRC_IDX] = generator_clock_pin_i;
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
    end else begin
      sync1_q <= src_raw;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // a level counts only once the second and third stage agree
  // a source that stops toggling simply stalls the output in its current phase
  assign agree = ~(sync2_q ^ sync3_q);

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      lvl_q <= '0;
    end else begin
      lvl_q <= (lvl_q & ~agree) | (sync3_q & agree);
    end
  end

  // ----------------------------------------------------------------
  // selected source edge detect
  // ----------------------------------------------------------------
  // limitation: sources faster than a quarter of the system clock alias
  logic sel_lvl;
  logic prev_lvl_q;
  logic [4:0] prev_src_q;
  logic sel_edge;
  logic src_same;

  assign sel_lvl = lvl_q[src_sel];
  assign sel_edge = (sel_lvl != prev_lvl_q);
  assign src_same = (src_sel == prev_src_q);

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      prev_lvl_q <= 1'b0;
      prev_src_q <= '0;
    end else begin
      prev_lvl_q <= sel_lvl;
      prev_src_q <= src_sel;
    end
  end

  // a change of source looks like an edge; it is masked so no phase is cut short
  assign dv.tick = sel_edge && src_same;

  // ----------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------
  logic want_run;

  assign want_run = gen_on && !(standby_i && !run_stby);

  // switching off lets the running period finish before the clock stops
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      state_q <= CGC_OFF;
    end else begin
      case (state_q)
        CGC_OFF: begin
          if (want_run) begin
            state_q <= CGC_RUN;
          end
        end
        CGC_RUN: begin
          if (!want_run) begin
            state_q <= CGC_DRAIN;
          end
        end
        CGC_DRAIN: begin
          // re-enable resumes the running period rather than restarting it
          if (want_run) begin
            state_q <= CGC_RUN;
          end else if (dv.done) begin
            state_q <= CGC_OFF;
          end
        end
        default: begin
          state_q <= CGC_OFF;
        end
      endcase
    end
  end

  // one period count feeds both total and high time, so they always match
  logic [CGC_HALF_W-1:0] per_cnt;

  assign per_cnt = cgc_periods(div_mode, div_fact);
  assign dv.go = (state_q != CGC_OFF);
  assign dv.stop_req = (state_q == CGC_DRAIN);
  assign dv.total = {per_cnt[CGC_HALF_W-2:0], 1'b0};
  assign dv.high = cgc_high(per_cnt, duty_bal);

  cgc_divider u_div (
    .clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i),
    .dv(dv)
  );

  // ----------------------------------------------------------------
  // outputs and dedicated pin
  // ----------------------------------------------------------------
  logic pin_q;
  logic pin_run;

  // the pin and gen_clk_o share one flop stage, so the pin never leads the consumers
  assign pin_run = (state_q != CGC_OFF) && pin_oe_bit;

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      gen_clk_o <= 1'b0;
      gen_clk_en_o <= 1'b0;
    end else begin
      gen_clk_o <= dv.gen_q;
      gen_clk_en_o <= dv.rise;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      pin_q <= 1'b0;
    end else if (pin_run) begin
      pin_q <= dv.gen_q;
    end else begin
      pin_q <= off_lvl;
    end
  end

  assign generator_clock_pin_o = pin_q;
  assign generator_clock_pin_oe_o = !pin_is_src;

endmodule : cgc_top

// >>> cgc_pkg.sv
// package with register map, field layout and timing constants of the clock generator
package cgc_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [11:0] CGC_GEN_CTRL_OFS = 12'h000;
  localparam logic [11:0] CGC_GEN_STAT_OFS = 12'h004;
  localparam logic [31:0] CGC_GEN_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] CGC_GEN_CTRL_WMASK = 32'hFFFF_3F1F;

  // ----------------------------------------------------------------
  // generator_control fields
  // ----------------------------------------------------------------
  localparam int CGC_SRC_LSB = 0;
  localparam int CGC_SRC_W = 5;
  localparam int CGC_GEN_ON_BIT = 8;
  localparam int CGC_DUTY_BAL_BIT = 9;
  localparam int CGC_OFF_LVL_BIT = 10;
  localparam int CGC_PIN_OE_BIT = 11;
  localparam int CGC_DIV_MODE_BIT = 12;
  localparam int CGC_RUN_STBY_BIT = 13;
  localparam int CGC_DIV_LSB = 16;
  localparam int CGC_DIV_W = 16;

  // ----------------------------------------------------------------
  // generator_status fields
  // ----------------------------------------------------------------
  localparam int CGC_ST_RUN_BIT = 0;
  localparam int CGC_ST_LVL_BIT = 1;
  localparam int CGC_ST_DRAIN_BIT = 2;
  localparam int CGC_ST_PINSRC_BIT = 3;

  // ----------------------------------------------------------------
  // divider sizing
  // ----------------------------------------------------------------
  localparam int CGC_NSRC = 32;
  localparam logic [4:0] CGC_PIN_SRC_IDX = 5'h01;
  localparam int CGC_HALF_W = 18;
  localparam logic [15:0] CGC_POW_MAX = 16'h000F;

  typedef enum logic [1:0] {
    CGC_OFF = 2'b00,
    CGC_RUN = 2'b01,
    CGC_DRAIN = 2'b11
  } cgc_state_e;

endpackage : cgc_pkg

// >>> cgc_div_if.sv
// interface carrying settings and timing between the controller and its divider
interface cgc_div_if;
  import cgc_pkg::*;
  logic tick;
  logic go;
  logic stop_req;
  logic [CGC_HALF_W-1:0] total;
  logic [CGC_HALF_W-1:0] high;
  logic gen_q;
  logic rise;
  logic done;

  modport ctrl (output tick, output go, output stop_req, output total, output high,
                input gen_q, input rise, input done);
  modport div (input tick, input go, input stop_req, input total, input high,
               output gen_q, output rise, output done);
endinterface : cgc_div_if

// >>> cgc_divider.sv
// half-period counter that builds the generator clock from source edges
module cgc_divider
  import cgc_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  cgc_div_if.div dv
);

  logic [CGC_HALF_W-1:0] cnt_q;
  logic [CGC_HALF_W-1:0] tot_q;
  logic [CGC_HALF_W-1:0] hi_q;
  logic gen_q;
  logic rise_q;
  logic at_end;

  assign at_end = (cnt_q == tot_q - 18'h0_0001);
  assign dv.gen_q = gen_q;
  assign dv.rise = rise_q;
  assign dv.done = dv.go && dv.tick && at_end && dv.stop_req;

  // ----------------------------------------------------------------
  // counter and shadowed settings
  // ----------------------------------------------------------------
  // settings are only taken while off or at a period boundary so a phase never shortens
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      cnt_q <= '0;
      tot_q <= 18'h0_0002;
      hi_q <= 18'h0_0001;
    end else if (!dv.go) begin
      tot_q <= dv.total;
      hi_q <= dv.high;
      cnt_q <= dv.total - 18'h0_0001;
    end else if (dv.tick) begin
      if (at_end) begin
        if (!dv.stop_req) begin
          cnt_q <= '0;
          tot_q <= dv.total;
          hi_q <= dv.high;
        end
      end else begin
        cnt_q <= cnt_q + 18'h0_0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // output level
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      gen_q <= 1'b0;
      rise_q <= 1'b0;
    end else if (!dv.go) begin
      gen_q <= 1'b0;
      rise_q <= 1'b0;
    end else if (dv.tick) begin
      if (at_end) begin
        gen_q <= !dv.stop_req;
        rise_q <= !dv.stop_req;
      end else begin
        gen_q <= (cnt_q + 18'h0_0001) < hi_q;
        rise_q <= 1'b0;
      end
    end else begin
      rise_q <= 1'b0;
    end
  end

endmodule : cgc_divider

// >>> cgc_src_model.sv
// behavioural clock sources and pin input standing in front of the generator
module cgc_src_model (
  input wire logic slow_i,
  output logic [31:0] src_clk_o,
  output logic pin_clk_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // edges sit 10 ns off the system clock edges so synchroniser counts are exact
  for (genvar n = 0; n < 32; n++) begin : g_src
    initial begin
      src_clk_o[n] = 1'b0;
      #10;
      forever begin
        #((n == 0 ? 160 : 240) * (slow_i ? 2 : 1));
        src_clk_o[n] = ~src_clk_o[n];
      end
    end
  end
  initial begin
    pin_clk_o = 1'b0;
    #10;
    forever begin
      #200;
      pin_clk_o = ~pin_clk_o;
    end
  end
endmodule : cgc_src_model

// >>> cgc_checker.sv
// port-level assertions of the clock generator
module cgc_checker
  import cgc_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  input wire logic [31:0] prdata_o,
  input wire logic standby_i,
  input wire logic generator_clock_pin_o,
  input wire logic generator_clock_pin_oe_o,
  input wire logic gen_clk_o,
  input wire logic gen_clk_en_o
);
  logic [31:0] ctrl_q;
  logic [31:0] wr_d;
  logic pin_src;
  logic gen_off;
  // shadow of the control word, so the checker needs no internal probes
  always_comb begin
    wr_d = ctrl_q;
    for (int b = 0; b < 4; b++) begin
      if (pstrb_i[b]) begin
        wr_d[8*b +: 8] = pwdata_i[8*b +: 8];
      end
    end
    wr_d = wr_d & CGC_GEN_CTRL_WMASK;
  end
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      ctrl_q <= CGC_GEN_CTRL_RST;
    end else if (psel_i && penable_i && pwrite_i && paddr_i == CGC_GEN_CTRL_OFS) begin
      ctrl_q <= wr_d;
    end
  end
  assign pin_src = ctrl_q[4:0] == CGC_PIN_SRC_IDX;
  assign gen_off = !ctrl_q[CGC_GEN_ON_BIT] || (standby_i && !ctrl_q[CGC_RUN_STBY_BIT]);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);
  a_oe_pin_src: assert property (generator_clock_pin_oe_o == !pin_src)
    else $error("pin enable wrong for source");
  a_off_level_pin: assert property ((!ctrl_q[CGC_PIN_OE_BIT] && !pin_src)[*2]
    |-> generator_clock_pin_o == $past(ctrl_q[CGC_OFF_LVL_BIT])) else $error("pin not off level");
  a_pin_follows_clk: assert property ((!gen_off && ctrl_q[CGC_PIN_OE_BIT] && !pin_src)[*8]
    |-> generator_clock_pin_o == gen_clk_o) else $error("pin does not follow clock");
  a_pulse_on_rise: assert property (gen_clk_en_o == $rose(gen_clk_o))
    else $error("enable pulse not on rising edge");
  a_high_min: assert property ($rose(gen_clk_o) |-> gen_clk_o[*2])
    else $error("runt high phase");
  a_low_min: assert property ($fell(gen_clk_o) |-> !gen_clk_o[*2])
    else $error("runt low phase");
  a_stop_low: assert property ((gen_off && !gen_clk_o)[*8] |=> !gen_clk_o)
    else $error("clock runs while off");
  a_ctrl_readback: assert property (psel_i && !penable_i && !pwrite_i
    && paddr_i == CGC_GEN_CTRL_OFS |=> prdata_o == $past(ctrl_q)) else $error("bad readback");
endmodule : cgc_checker

bind cgc_top cgc_checker u_cgc_checker (.clk_sys_i, .rst_b_i, .psel_i, .penable_i, .pwrite_i,
  .paddr_i, .pwdata_i, .pstrb_i, .prdata_o, .standby_i, .generator_clock_pin_o,
  .generator_clock_pin_oe_o, .gen_clk_o, .gen_clk_en_o);

// >>> cgc_top_bench.sv
// self-checking bench: apb register access and generator output measurements
module cgc_top_bench;
  import cgc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] pstrb = 4'h0;
  logic standby = 1'b0;
  logic slow = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, pin_i, pin_o, pin_oe, gen_clk, gen_en;
  logic [31:0] src_clk;
  int num_errors = 0;
  int checks_done = 0;
  // period and high time in system cycles: sources have half periods of 4, 6 and pin 5
  localparam logic [31:0] CFG [7] = '{32'h0001_0900, 32'h0000_0900, 32'h0003_0900,
    32'h0003_0B00, 32'h0001_1900, 32'h0001_0902, 32'h0001_0901};
  localparam int PER [7] = '{8, 8, 24, 24, 32, 12, 10};
  localparam int HI [7] = '{4, 4, 8, 12, 16, 6, 5};

  always #20 clk_sys_i = ~clk_sys_i;

  cgc_src_model u_cgc_src_model (.slow_i(slow), .src_clk_o(src_clk), .pin_clk_o(pin_i));
  cgc_top u_cgc_top (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .pstrb_i(pstrb), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .src_clk_i(src_clk), .standby_i(standby), .generator_clock_pin_i(pin_i),
    .generator_clock_pin_o(pin_o), .generator_clock_pin_oe_o(pin_oe),
    .gen_clk_o(gen_clk), .gen_clk_en_o(gen_en));

  task automatic finish_test;
    if (num_errors == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s, input logic xe, input logic [31:0] x);
    int n;
    @(posedge clk_sys_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk_sys_i);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      num_errors++;
      finish_test();
    end
    if (!w) begin
      chk("rdata", x, prdata);
    end
    chk("slverr", {31'b0, xe}, {31'b0, pslverr});
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [31:0] d);
    apb(1'b1, CGC_GEN_CTRL_OFS, d, 4'hF, 1'b0, 32'h0000_0000);
  endtask : wr

  task automatic measure(input int per, input int hi);
    int n, h;
    // the first pulses may still belong to the previous divisor
    for (int k = 0; k < 4; k++) begin
      n = 0;
      h = 0;
      do begin
        @(posedge clk_sys_i);
        n++;
        h += (gen_clk === 1'b1);
      end while (gen_en !== 1'b1 && n < 400);
      if (gen_en !== 1'b1) begin
        num_errors++;
        finish_test();
      end
    end
    chk("period", 32'(per), 32'(n));
    chk("high", 32'(hi), 32'(h));
  endtask : measure

  task automatic quiet(input logic lvl);
    int c;
    repeat (40) @(posedge clk_sys_i);
    c = 0;
    repeat (48) begin
      @(posedge clk_sys_i);
      c += (gen_en === 1'b1);
    end
    chk("pulses", 32'h0000_0000, 32'(c));
    chk("pin", {31'b0, lvl}, {31'b0, pin_o});
  endtask : quiet

  initial begin
    repeat (8) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    apb(1'b0, CGC_GEN_CTRL_OFS, 32'h0000_0000, 4'h0, 1'b0, CGC_GEN_CTRL_RST);
    apb(1'b0, 12'h008, 32'h0000_0000, 4'h0, 1'b1, 32'h0000_0000);
    apb(1'b1, CGC_GEN_STAT_OFS, 32'hFFFF_FFFF, 4'hF, 1'b1, 32'h0000_0000);
    apb(1'b1, CGC_GEN_CTRL_OFS, 32'hFFFF_FEFF, 4'h3, 1'b0, 32'h0000_0000);
    apb(1'b0, CGC_GEN_CTRL_OFS, 32'h0000_0000, 4'h0, 1'b0, 32'h0000_3E1F);
    wr(32'h0000_0400);
    repeat (3) @(posedge clk_sys_i);
    chk("pin off", 32'h0000_0001, {31'b0, pin_o});
    wr(32'h0000_0001);
    repeat (2) @(posedge clk_sys_i);
    chk("pin oe", 32'h0000_0000, {31'b0, pin_oe});
    apb(1'b0, CGC_GEN_STAT_OFS, 32'h0000_0000, 4'h0, 1'b0, 32'h0000_0008);
    for (int i = 0; i < 7; i++) begin
      wr(CFG[i]);
      measure(PER[i], HI[i]);
      chk("oe", {31'b0, CFG[i][4:0] != CGC_PIN_SRC_IDX}, {31'b0, pin_oe});
    end
    wr(32'h0001_0900);
    slow <= 1'b1;
    measure(16, 8);
    slow <= 1'b0;
    standby <= 1'b1;
    quiet(1'b0);
    wr(32'h0001_2900);
    measure(8, 4);
    standby <= 1'b0;
    wr(32'h0001_0C00);
    quiet(1'b1);
    finish_test();
  end
endmodule : cgc_top_bench
